// [crc8_calc.sv]
// combinational 8-bit frame check over a 24-bit word
`timescale 1ns/1ps
`default_nettype none
module crc8_calc
    import fault_pec_pkg::*;
(
    input  wire logic [23:0] data,  // word to protect
    output logic      [7:0]  crc    // frame check byte
);

    // msb first, zero start, no final inversion
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    assign crc = crc8(data);

endmodule // crc8_calc
`default_nettype wire

// [fault_alert_pec_logic.sv]
// fault alerts, link watchdog and frame checking behind a serial link
// Behaviour
// - every fault sets flag and alert pin
// - no accepted link frame past period: timeout
// - timeout sets its fault flag
// - timeout forces alarm current on loop
// - direction pin picks upscale or downscale alarm
// - 32-bit writes carry check in low byte
// - bad check: reject, alert, set flag
// - fault read clears check-error flag
// - 32-bit readback appends check byte
// - loop off target sets low/high flag
// - low or high flag drives alert
`timescale 1ns/1ps
`default_nettype none
module fault_alert_pec_logic
    import fault_pec_pkg::*;
#(
    parameter int unsigned WDT_UNIT_CYCLES = WDT_UNIT_CYC  // cycles per step
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        link_sclk,
    input  wire logic        link_sync_n,
    input  wire logic        link_sdi,
    output logic             link_sdo,
    output logic             link_sdo_oe,
    input  wire logic        alarm_dir,
    input  wire logic [15:0] meas_current,
    output logic [15:0]      loop_code,
    output logic             fault_alert
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // byte-lane merge for bus writes
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // true when a exceeds b by more than the tolerance
    function automatic logic over_tol(input logic [15:0] a,
                                      input logic [15:0] b);
        return (a > b) && ((a - b) > TOL_CODES);
    endfunction

    // mapped bus word address
    function automatic logic mapped(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_LOOP || a == OFS_FAULT
            || a == OFS_MEAS;
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [5:0]  lbit_q;      // link bit count, cleared by sync high
    logic [5:0]  lend_q;      // bit count held as sync rises
    logic [31:0] lsh_q;       // link receive shifter
    logic [2:0]  sync_s_q;    // sync level into aclk, [2] for edge
    logic [1:0]  dir_s_q;     // alarm direction synchroniser
    logic [31:0] rx_q;        // captured frame bits
    logic [5:0]  len_q;       // captured frame length
    logic        proc_q;      // frame ready for decode
    logic [31:0] tx_q;        // readback word for next frame
    logic [3:0]  ctrl_q;      // watchdog field
    logic [15:0] loop_q;      // programmed loop code
    logic [15:0] loop_code_q; // code driven to the converter
    fault_t      fault_q;
    fault_t      fault_d;
    logic        alert_q;
    logic [31:0] wdt_cnt_q;   // cycles since last valid frame
    logic [31:0] wdt_limit;
    logic        wdt_expire;
    frame_t      frame;
    logic        is_long;
    logic        is_short;
    logic [7:0]  rx_crc;
    logic [7:0]  tx_crc;
    logic        frame_ok;    // accepted frame, one cycle
    logic        pec_err;     // failed check, one cycle
    logic [15:0] link_rd;
    logic [23:0] tx_word;
    logic        fault_rd;
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        bus_wr;
    logic        ar_hs;

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------
    // the link clock only runs inside frames, so sync high ends the count
    always_ff @(posedge link_sclk or posedge link_sync_n) begin
        if (link_sync_n) begin
            lbit_q <= '0;
        end else if (lbit_q != FRAME_SAT) begin
            lbit_q <= lbit_q + 6'h01;
        end
    end

    // the count clears as sync rises, so its last value is kept here
    always_ff @(posedge link_sync_n) begin
        lend_q <= lbit_q;
    end

    // sample the host data on the rising link edge
    always_ff @(posedge link_sclk) begin
        lsh_q <= {lsh_q[30:0], link_sdi};
    end

    // tx_q only changes between frames, so it is steady while shifted
    always_comb begin
        if (lbit_q < FRAME_LONG) begin
            link_sdo = tx_q[5'(6'h1f - lbit_q)];
        end else begin
            link_sdo = 1'b0;
        end
    end
    assign link_sdo_oe = ~link_sync_n;  // drive only inside a frame

    // ------------------------------------------------------------------
    // crossing into aclk
    // ------------------------------------------------------------------
    // sync is a level; edge taken from stages two and three only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_s_q <= 3'h7;
            dir_s_q  <= 2'h0;
        end else begin
            sync_s_q <= {sync_s_q[1:0], link_sync_n};
            dir_s_q  <= {dir_s_q[0], alarm_dir};
        end
    end

    // link shifter and held length are frozen once sync is high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_q   <= '0;
            len_q  <= '0;
            proc_q <= 1'b0;
        end else begin
            proc_q <= sync_s_q[1] & ~sync_s_q[2];
            if (sync_s_q[1] & ~sync_s_q[2]) begin
                rx_q  <= lsh_q;
                len_q <= lend_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // frame decode and check
    // ------------------------------------------------------------------
    crc8_calc u_rx_crc (
        .data (rx_q[31:8]),
        .crc  (rx_crc)
    );

    always_comb begin
        is_long  = len_q == FRAME_LONG;
        is_short = len_q == FRAME_SHORT;
        frame    = is_long ? frame_t'(rx_q[31:8]) : frame_t'(rx_q[23:0]);
        // other lengths are dropped silently
        frame_ok = proc_q && (is_short || (is_long && rx_crc == rx_q[7:0]));
        pec_err  = proc_q && is_long && rx_crc != rx_q[7:0];
    end

    // readback source for a link read
    always_comb begin
        unique case (frame.addr)
            LADR_LOOP:  link_rd = loop_q;
            LADR_CTRL:  link_rd = {12'h000, ctrl_q};
            LADR_FAULT: link_rd = {12'h000, fault_q};
            LADR_MEAS:  link_rd = meas_current;
            default:    link_rd = 16'h0000;
        endcase
        tx_word = {1'b0, frame.addr, link_rd};
    end

    crc8_calc u_tx_crc (
        .data (tx_word),
        .crc  (tx_crc)
    );

    // readback word waits for the next frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_q <= '0;
        end else if (frame_ok && frame.rd) begin
            tx_q <= {tx_word, is_long ? tx_crc : 8'h00};
        end
    end

    // ------------------------------------------------------------------
    // bus write channel
    // ------------------------------------------------------------------
    assign awready = !aw_have_q && !bvalid_q;
    assign wready  = !w_have_q && !bvalid_q;
    assign bus_wr  = aw_have_q && w_have_q && !bvalid_q;

    // address and data are taken in either order, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            if (bus_wr) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // a link write wins over a bus write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
        end else if (frame_ok && !frame.rd && frame.addr == LADR_CTRL) begin
            ctrl_q <= frame.data[WDT_LSB +: WDT_W];
        end else if (bus_wr && awaddr_q == OFS_CTRL) begin
            ctrl_q <= 4'(merge({28'h0, ctrl_q}, wdata_q, wstrb_q) >> WDT_LSB);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_q <= LOOP_RST;
        end else if (frame_ok && !frame.rd && frame.addr == LADR_LOOP) begin
            loop_q <= frame.data;
        end else if (bus_wr && awaddr_q == OFS_LOOP) begin
            loop_q <= 16'(merge({16'h0, loop_q}, wdata_q, wstrb_q));
        end
    end

    // ------------------------------------------------------------------
    // bus read channel
    // ------------------------------------------------------------------
    assign arready = !rvalid_q;
    assign ar_hs   = arvalid && arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rresp_q  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFS_CTRL:  rdata_q <= {28'h0, ctrl_q};
                OFS_LOOP:  rdata_q <= {16'h0, loop_q};
                OFS_FAULT: rdata_q <= {28'h0, fault_q};
                OFS_MEAS:  rdata_q <= {16'h0, meas_current};
                default:   rdata_q <= 32'h0;
            endcase
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

    // ------------------------------------------------------------------
    // link watchdog
    // ------------------------------------------------------------------
    // field zero turns the watchdog off
    assign wdt_limit  = 32'(WDT_UNIT_CYCLES * ctrl_q);
    // a stuck count must not outlive the frame that restarts it
    assign wdt_expire = (wdt_limit != 32'h0) && (wdt_cnt_q > wdt_limit) && !frame_ok;

    // only an accepted frame or a zero watchdog field clears the count; the count stops once out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_cnt_q <= '0;
        end else if (frame_ok || wdt_limit == 32'h0) begin
            wdt_cnt_q <= '0;
        end else if (!wdt_expire) begin
            wdt_cnt_q <= wdt_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // fault flags and alert
    // ------------------------------------------------------------------
    assign fault_rd = (frame_ok && frame.rd && frame.addr == LADR_FAULT)
                   || (ar_hs && araddr == OFS_FAULT);

    // a new event beats a clear in the same cycle
    always_comb begin
        fault_d.pec     = pec_err | (fault_q.pec & ~fault_rd);
        fault_d.timeout = wdt_expire | (fault_q.timeout & ~frame_ok);
        fault_d.low     = over_tol(loop_code_q, meas_current);
        fault_d.high    = over_tol(meas_current, loop_code_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_q <= '0;
            alert_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
            alert_q <= |fault_d;
        end
    end
    assign fault_alert = alert_q;

    // ------------------------------------------------------------------
    // loop code with alarm override
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_code_q <= LOOP_RST;
        end else if (fault_q.timeout) begin
            loop_code_q <= dir_s_q[1] ? ALARM_UP : ALARM_DOWN;
        end else begin
            loop_code_q <= loop_q;
        end
    end
    assign loop_code = loop_code_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_sync_rise;
        sync_s_q[1] && !sync_s_q[2];
    endsequence

    sequence s_bad_frame;
        pec_err ##1 fault_q.pec;
    endsequence

    a_frame_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        s_sync_rise |=> proc_q && len_q == $past(lend_q))
        else $error("frame not captured after sync");

    a_bad_frame_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        pec_err |=> fault_q.pec && alert_q)
        else $error("check failure not flagged");

    a_bad_frame_nowr: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bad_frame |-> $stable(loop_q) && $stable(ctrl_q))
        else $error("rejected frame changed a register");

    a_bad_frame_nokick: assert property (@(posedge aclk) disable iff (!aresetn)
        pec_err && wdt_cnt_q != 32'h0 && wdt_limit == $past(wdt_limit)
        |=> wdt_cnt_q != 32'h0)
        else $error("rejected frame restarted watchdog");

    a_read_clears_pec: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_rd && !pec_err |=> !fault_q.pec)
        else $error("fault read left check flag set");

    a_timeout_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        wdt_expire |=> fault_q.timeout && alert_q)
        else $error("watchdog expiry not flagged");

    a_alarm_level: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_q.timeout |=> loop_code_q == ($past(dir_s_q[1]) ? ALARM_UP : ALARM_DOWN))
        else $error("alarm code not driven");

    a_loop_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (loop_code_q > meas_current) && (loop_code_q - meas_current > TOL_CODES)
        |=> fault_q.low && !fault_q.high)
        else $error("low loop current not flagged");

    a_alert_loop: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_q.low || fault_q.high |-> alert_q)
        else $error("loop flag without alert");

    a_readback_crc: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_ok && frame.rd && is_long |=> tx_q[7:0] == $past(tx_crc)
        && tx_q[31:8] == $past(tx_word))
        else $error("readback check byte wrong");

endmodule // fault_alert_pec_logic
`default_nettype wire

// [fault_pec_pkg.sv]
// constants and carrier types shared by the fault-alert and frame-check logic
package fault_pec_pkg;

    // ------------------------------------------------------------------
    // clock and time
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 50_000_000;  // system clock rate
    localparam int unsigned WDT_UNIT_US   = 1000;        // watchdog step, microseconds
    localparam int unsigned WDT_UNIT_CYC  = (CLK_HZ / 1_000_000) * WDT_UNIT_US;

    // ------------------------------------------------------------------
    // bus map (byte addresses) and responses
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // control, watchdog field
    localparam logic [7:0] OFS_LOOP   = 8'h04;  // programmed loop code
    localparam logic [7:0] OFS_FAULT  = 8'h08;  // fault flags, read clears check error
    localparam logic [7:0] OFS_MEAS   = 8'h0c;  // measured loop code
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // link register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] LADR_LOOP  = 7'h01;
    localparam logic [6:0] LADR_CTRL  = 7'h02;
    localparam logic [6:0] LADR_FAULT = 7'h03;
    localparam logic [6:0] LADR_MEAS  = 7'h04;

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned WDT_LSB   = 0;      // watchdog field position
    localparam int unsigned WDT_W     = 4;      // watchdog field width
    localparam logic [3:0]  CTRL_RST  = 4'h0;   // watchdog off after reset
    localparam logic [15:0] LOOP_RST  = 16'h0000;

    // ------------------------------------------------------------------
    // frame check and frame lengths
    // ------------------------------------------------------------------
    localparam logic [7:0] CRC_POLY    = 8'h07;  // x^8 + x^2 + x + 1
    localparam logic [7:0] CRC_INIT    = 8'h00;
    localparam logic [5:0] FRAME_SHORT = 6'h18;  // 24 bits, unchecked
    localparam logic [5:0] FRAME_LONG  = 6'h20;  // 32 bits, checked
    localparam logic [5:0] FRAME_SAT   = 6'h3f;  // bit counter ceiling

    // ------------------------------------------------------------------
    // loop current levels
    // ------------------------------------------------------------------
    localparam int unsigned FSR_CODES  = 65536;
    localparam int unsigned TOL_PPM    = 100;    // 0.01 % of full scale
    localparam logic [15:0] TOL_CODES  = 16'(FSR_CODES * TOL_PPM / 1_000_000);
    localparam logic [15:0] ALARM_UP   = 16'hffff;
    localparam logic [15:0] ALARM_DOWN = 16'h0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rd;     // 1 = readback request
        logic [6:0] addr;   // link register address
        logic [15:0] data;  // write data
    } frame_t;

    typedef struct packed {
        logic high;     // loop current above target
        logic low;      // loop current below target
        logic timeout;  // link watchdog expired
        logic pec;      // frame check failed
    } fault_t;

endpackage

// [link_host_model.sv]
// host-side model of the serial link partner
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// host link driver, sclk idles low
// ------------------------------------------
module link_host_model (
    output logic      link_sclk,
    output logic      link_sync_n,
    output logic      link_sdi,
    input  wire logic link_sdo
);
    initial begin
        link_sclk = 1'b0; // clock stands still between frames
        link_sync_n = 1'b0; // a rise at start clears the device bit count
        link_sdi = 1'b0;
        #1 link_sync_n = 1'b1;
    end
    // check byte over the 24-bit word
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // one 32-bit frame; bad flips check bits to provoke a refusal
    task automatic frame(input logic [23:0] w, input logic [7:0] bad, output logic [31:0] rx);
        logic [31:0] s;
        s = {w, crc8(w) ^ bad};
        rx = 32'h0;
        link_sync_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            link_sdi = s[i];
            #15 rx = {rx[30:0], link_sdo}; // host takes each bit just before the rising edge
            link_sclk = 1'b1;
            #15 link_sclk = 1'b0;
        end
        #15 link_sync_n = 1'b1;
        link_sdi = ~link_sdi; // released line shows no stale bit
    endtask
endmodule // link_host_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the fault-alert and frame-check block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fault_pec_pkg::*;
();
    // ------------------------------------------
    // signals
    // ------------------------------------------
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alarm_dir;
    logic awready, wready, bvalid, arready, rvalid, link_sdo, fault_alert;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rx;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] meas_current, loop_code, meas_ofs, v;
    wire logic link_sclk, link_sync_n, link_sdi;
    logic [33:0] exp_q[$]; // expected {rresp, rdata}
    int n_fail, samples_checked, cyc, seed;

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // short watchdog step keeps the timeout run brief
    fault_alert_pec_logic #(.WDT_UNIT_CYCLES(8)) fault_alert_pec_logic_i (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .link_sclk, .link_sync_n, .link_sdi, .link_sdo, .link_sdo_oe(),
        .alarm_dir, .meas_current, .loop_code, .fault_alert);
    link_host_model link_host_model_i (.link_sclk, .link_sync_n, .link_sdi, .link_sdo);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // bus write: each channel released when taken
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        chk(32'(bresp), 32'(RESP_OKAY));
        bready <= 1'b0;
    endtask
    // bus read: expectation noted, the monitor compares
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        exp_q.push_back({r, e});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask
    // read monitor takes the oldest note per answer
    always @(posedge aclk) begin
        if (rvalid && rready && exp_q.size() > 0) begin
            chk(rdata, exp_q[0][31:0]);
            chk(32'(rresp), 32'(exp_q[0][33:32]));
            void'(exp_q.pop_front());
        end
    end
    // measured code follows the driven code plus an offset
    always @(posedge aclk) meas_current <= loop_code + meas_ofs;
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        seed = 60527;
        {n_fail, samples_checked, cyc} = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, meas_current, meas_ofs} = 0;
        wstrb = 4'hf;
        alarm_dir = 1'b1;
        wt(5);
        aresetn <= 1'b1;
        wt(4);
        v = 16'h1000 | (16'($random(seed)) & 16'h0fff);
        bus_wr(OFS_LOOP, {16'h0, v});
        bus_rd(OFS_LOOP, {16'h0, v}, RESP_OKAY);
        bus_rd(8'h10, 32'h0, RESP_SLVERR);
        chk(32'(loop_code), 32'(v));
        v = v ^ (16'($random(seed)) & 16'h0fff);
        link_host_model_i.frame({1'b0, LADR_LOOP, v}, 8'h00, rx);
        wt(8);
        chk(32'(loop_code), 32'(v));
        link_host_model_i.frame({1'b0, LADR_LOOP, ~v}, 8'h01, rx);
        wt(8);
        chk(32'(loop_code), 32'(v));
        chk(32'(fault_alert), 32'h1);
        bus_rd(OFS_FAULT, 32'h1, RESP_OKAY);
        bus_rd(OFS_FAULT, 32'h0, RESP_OKAY);
        wt(2);
        chk(32'(fault_alert), 32'h0);
        link_host_model_i.frame({1'b1, LADR_LOOP, 16'h0}, 8'h00, rx);
        wt(8);
        link_host_model_i.frame({1'b1, LADR_MEAS, 16'h0}, 8'h00, rx);
        wt(8);
        chk(rx, {1'b0, LADR_LOOP, v, link_host_model_i.crc8({1'b0, LADR_LOOP, v})});
        meas_ofs <= 16'h0007;
        wt(4);
        chk(32'(fault_alert), 32'h1);
        bus_rd(OFS_FAULT, 32'h8, RESP_OKAY);
        meas_ofs <= 16'hfff9;
        wt(4);
        bus_rd(OFS_FAULT, 32'h4, RESP_OKAY);
        meas_ofs <= 16'h0006;
        wt(4);
        chk(32'(fault_alert), 32'h0);
        meas_ofs <= 16'h0000;
        bus_wr(OFS_CTRL, 32'h1);
        wt(20);
        chk(32'(loop_code), 32'(ALARM_UP));
        bus_rd(OFS_FAULT, 32'h2, RESP_OKAY);
        alarm_dir <= 1'b0;
        wt(5);
        chk(32'(loop_code), 32'(ALARM_DOWN));
        link_host_model_i.frame({1'b0, LADR_CTRL, 16'h0}, 8'h01, rx);
        wt(8);
        chk(32'(loop_code), 32'(ALARM_DOWN));
        bus_rd(OFS_FAULT, 32'h3, RESP_OKAY);
        link_host_model_i.frame({1'b0, LADR_CTRL, 16'h0}, 8'h00, rx);
        wt(8);
        chk(32'(loop_code), 32'(v));
        chk(32'(fault_alert), 32'h0);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
